// ==== core/emcp_ctrl.sv ====
// External memory port control pins: clocks, strobes, chip enables, hold
//
// Function
// - Strap picks interface clock; external pin default
// - Divided output clock, ratio one, two, four
// - Full output clock at interface clock rate
// - Sync read pin: address strobe or read enable
// - First strobe pin muxed by memory type
// - Second strobe pin muxed by memory type
// - Third strobe pin is the write strobe for every memory type
// - Dedicated sync output enable for space three
// - Bus request output shows interface needs bus
// - Hold request answered with hold acknowledge
// - Strap 00 pin, 01 CPU/4, 10 CPU/6
// - Exactly one chip enable per access
`timescale 1ns/1ps
`include "emcp_defs.svh"
module emcp_ctrl #(
  parameter int AW = 20
) (
  // Clock, reset, freeze
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Access requests from the transfer engine
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  output logic req_ready,
  output logic req_done,
  // Clock pins
  input wire logic [1:0] clk_src_strap_pins,
  input wire logic ext_if_clk_in,
  output logic mem_clk_out_full,
  output logic mem_clk_out_div,
  // Memory control pins, outputs active low, ready input active high, released while ctl_oe_b is high
  output logic [3:0] chip_en_b,
  output logic rd_strobe_b,
  output logic oe_strobe_b,
  output logic wr_strobe_b,
  output logic fifo_space_out_en_b,
  output logic ctl_oe_b,
  input wire logic async_ready_in,
  // Arbitration
  input wire logic host_hold_req_in,
  output logic host_hold_ack_out,
  output logic bus_req_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic ext_s;
  logic rdy_s;
  logic hreq_s;
  logic [1:0] strap_s;

  emcp_sync3 #(.W(1), .RST(1'b0)) u_sync_clk (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .pin(ext_if_clk_in), .val(ext_s)
  );
  emcp_sync3 #(.W(1), .RST(1'b1)) u_sync_rdy (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .pin(async_ready_in), .val(rdy_s)
  );
  emcp_sync3 #(.W(1), .RST(1'b0)) u_sync_hold (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .pin(host_hold_req_in), .val(hreq_s)
  );
  emcp_sync3 #(.W(2), .RST(2'h0)) u_sync_strap (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .pin(clk_src_strap_pins), .val(strap_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture: taken once after release, when the filter has settled
  logic [1:0] clk_src_select_q;
  logic [2:0] strap_wait_q;
  logic strap_done_q;
  wire strap_take = !strap_done_q && (strap_wait_q == `EMCP_STRAP_SETTLE);
  // Reserved code falls back to the external pin
  wire [1:0] strap_dec = (strap_s == 2'h3) ? `EMCP_STRAP_EXT : strap_s;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_src_select_q <= `EMCP_STRAP_EXT;
      strap_wait_q <= 3'h0;
      strap_done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!strap_done_q)
        strap_wait_q <= strap_wait_q + 3'h1;
      if (strap_take)
      begin
        clk_src_select_q <= strap_dec;
        strap_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [2:0] ctrl_q;
  logic [7:0] mtype_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  wire hit_ctrl = (paddr == `EMCP_OFS_CTRL);
  wire hit_mtype = (paddr == `EMCP_OFS_MTYPE);
  wire hit_stat = (paddr == `EMCP_OFS_STAT);
  wire hit_any = hit_ctrl || hit_mtype || hit_stat;
  wire setup_ph = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire [1:0] div_sel = ctrl_q[`EMCP_CTRL_DIV_LSB +: 2];
  wire ren_sel = ctrl_q[`EMCP_CTRL_REN_BIT];
  logic busy;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`EMCP_STAT_SRC_LSB +: 2] = clk_src_select_q;
    stat_word[`EMCP_STAT_ACK_BIT] = host_hold_ack_out;
    stat_word[`EMCP_STAT_BUSY_BIT] = busy;
    stat_word[`EMCP_STAT_HREQ_BIT] = hreq_s;
    stat_word[`EMCP_STAT_RDY_BIT] = rdy_s;
  end

  assign rd_word = hit_ctrl ? {29'h0, ctrl_q}
                 : hit_mtype ? {24'h0, mtype_q}
                 : hit_stat ? stat_word : 32'h0000_0000;

  // Read data are fetched in the setup cycle so the access phase needs no wait
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `EMCP_CTRL_RST;
      mtype_q <= `EMCP_MTYPE_RST;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (setup_ph)
      begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
        slverr_q <= !hit_any;
      end
      if (wr_acc && hit_ctrl)
        ctrl_q <= pwdata[2:0];
      if (wr_acc && hit_mtype)
        mtype_q <= pwdata[7:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = slverr_q && psel && penable;

  ////////////////////////////////////////////////////////////////////////////
  // Interface clock and output clocks
  logic full_q;
  logic div_q;
  logic div_out_q;
  logic ext_prev_q;
  logic cpu_tick;
  logic div_tick;
  wire use_ext = (clk_src_select_q == `EMCP_STRAP_EXT);
  wire [1:0] cpu_half = (clk_src_select_q == `EMCP_STRAP_CPU6) ? `EMCP_CPU6_HALF
                      : `EMCP_CPU4_HALF;
  wire half_tick = use_ext ? (ext_s != ext_prev_q) : cpu_tick;
  wire full_d = half_tick ? !full_q : full_q;
  wire rise = half_tick && !full_q;
  wire [1:0] div_rises = (div_sel == `EMCP_DIV_BY2) ? `EMCP_DIV2_RISES
                       : `EMCP_DIV4_RISES;
  wire div_d = div_tick ? !div_q : div_q;
  wire div_out_d = (div_sel == `EMCP_DIV_BY1) ? full_d : div_d;

  emcp_hcnt #(.W(2)) u_cpu_div (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .en(!use_ext), .limit(cpu_half), .tick(cpu_tick)
  );
  emcp_hcnt #(.W(2)) u_out_div (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .en(rise), .limit(div_rises), .tick(div_tick)
  );

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      full_q <= 1'b0;
      div_q <= 1'b0;
      div_out_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      full_q <= full_d;
      div_q <= div_d;
      div_out_q <= div_out_d;
      ext_prev_q <= ext_s;
    end
  end

  assign mem_clk_out_full = full_q;
  assign mem_clk_out_div = div_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer and hold arbitration
  emcp_pkg::emcp_state_e state_q;
  emcp_pkg::emcp_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [1:0] space_q;
  logic wr_q;
  wire [1:0] req_space = req_addr[AW-1 -: 2];
  wire take = req_valid && req_ready;
  wire [1:0] cur_type = mtype_q[{space_q, 1'b0} +: 2];
  wire is_async = (cur_type == emcp_pkg::MT_ASYNC) || (cur_type == emcp_pkg::MT_RSVD);
  wire is_sdram = (cur_type == emcp_pkg::MT_SDRAM);
  wire is_sync = (cur_type == emcp_pkg::MT_SYNC);
  wire cnt_end = (cnt_q == 4'h0);
  wire acc_done = (state_q == emcp_pkg::ST_TAIL) && cnt_end;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_end ? 4'h0 : cnt_q - 4'h1;
    case (state_q)
      emcp_pkg::ST_IDLE:
      begin
        // Hold wins over a new access; the access only waits
        if (hreq_s)
          state_d = emcp_pkg::ST_PARK;
        else if (take)
        begin
          state_d = emcp_pkg::ST_SETUP;
          cnt_d = `EMCP_SETUP_CYC - 4'h1;
        end
      end
      emcp_pkg::ST_SETUP:
        if (cnt_end)
        begin
          state_d = emcp_pkg::ST_STROBE;
          cnt_d = `EMCP_STROBE_CYC - 4'h1;
        end
      emcp_pkg::ST_STROBE:
        if (cnt_end)
        begin
          state_d = (is_async && !rdy_s) ? emcp_pkg::ST_WAITRDY : emcp_pkg::ST_TAIL;
          cnt_d = `EMCP_TAIL_CYC - 4'h1;
        end
      emcp_pkg::ST_WAITRDY:
        if (rdy_s)
        begin
          state_d = emcp_pkg::ST_TAIL;
          cnt_d = `EMCP_TAIL_CYC - 4'h1;
        end
      emcp_pkg::ST_TAIL:
        if (cnt_end)
          state_d = hreq_s ? emcp_pkg::ST_PARK : emcp_pkg::ST_IDLE;
      emcp_pkg::ST_PARK:
        state_d = hreq_s ? emcp_pkg::ST_HOLD : emcp_pkg::ST_IDLE;
      emcp_pkg::ST_HOLD:
        if (!hreq_s)
          state_d = emcp_pkg::ST_IDLE;
      default:
        state_d = emcp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= emcp_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      space_q <= 2'h0;
      wr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (take)
      begin
        space_q <= req_space;
        wr_q <= req_write;
      end
    end
  end

  assign req_ready = (state_q == emcp_pkg::ST_IDLE) && !hreq_s && strap_done_q;
  assign busy = (state_q != emcp_pkg::ST_IDLE) && (state_q != emcp_pkg::ST_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // Pin values, decoded from the current phase and registered
  wire in_acc = (state_q == emcp_pkg::ST_SETUP) || (state_q == emcp_pkg::ST_STROBE)
             || (state_q == emcp_pkg::ST_WAITRDY) || (state_q == emcp_pkg::ST_TAIL);
  wire strb_ph = (state_q == emcp_pkg::ST_STROBE) || (state_q == emcp_pkg::ST_WAITRDY);
  wire addr_ph = (state_q == emcp_pkg::ST_SETUP);
  wire rd_act = strb_ph && !wr_q;
  wire wr_act = strb_ph && wr_q;
  wire sync_rd_pin = ren_sel ? rd_act : addr_ph;
  wire rd_pin_act = is_sdram ? strb_ph : is_sync ? sync_rd_pin : rd_act;
  wire oe_pin_act = is_sdram ? addr_ph : is_sync ? rd_act : (in_acc && !wr_q);
  wire we_pin_act = wr_act;
  wire fifo_act = is_sync && rd_act && (space_q == `EMCP_SPACE_FIFO);
  wire released = (state_q == emcp_pkg::ST_PARK) || (state_q == emcp_pkg::ST_HOLD);
  wire [3:0] ce_onehot = 4'h1 << space_q;
  wire [3:0] ce_d = in_acc ? ~ce_onehot : 4'hF;

  logic [3:0] ce_q;
  logic rd_q;
  logic oe_q;
  logic we_q;
  logic fifo_q;
  logic ctl_oe_q;
  logic ack_q;
  logic breq_q;
  logic done_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ce_q <= 4'hF;
      rd_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      fifo_q <= 1'b1;
      ctl_oe_q <= 1'b0;
      ack_q <= 1'b0;
      breq_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ce_q <= ce_d;
      rd_q <= !(in_acc && rd_pin_act);
      oe_q <= !(in_acc && oe_pin_act);
      we_q <= !(in_acc && we_pin_act);
      fifo_q <= !fifo_act;
      // Pins float one cycle before the acknowledge rises
      ctl_oe_q <= released;
      ack_q <= (state_q == emcp_pkg::ST_HOLD) && hreq_s;
      breq_q <= req_valid || busy;
      done_q <= acc_done;
    end
  end

  assign chip_en_b = ce_q;
  assign rd_strobe_b = rd_q;
  assign oe_strobe_b = oe_q;
  assign wr_strobe_b = we_q;
  assign fifo_space_out_en_b = fifo_q;
  assign ctl_oe_b = ctl_oe_q;
  assign host_hold_ack_out = ack_q;
  assign bus_req_out = breq_q;
  assign req_done = done_q;
endmodule

// ==== core/emcp_defs.svh ====
// Offsets, field positions, reset values and cycle counts of the memory control pin block
`ifndef EMCP_DEFS_SVH
`define EMCP_DEFS_SVH
`define EMCP_OFS_CTRL 8'h00
`define EMCP_OFS_MTYPE 8'h04
`define EMCP_OFS_STAT 8'h08
`define EMCP_CTRL_DIV_LSB 0
`define EMCP_CTRL_REN_BIT 2
`define EMCP_CTRL_RST 3'h0
`define EMCP_MTYPE_RST 8'h00
`define EMCP_STAT_SRC_LSB 0
`define EMCP_STAT_ACK_BIT 2
`define EMCP_STAT_BUSY_BIT 3
`define EMCP_STAT_HREQ_BIT 4
`define EMCP_STAT_RDY_BIT 5
`define EMCP_STRAP_EXT 2'h0
`define EMCP_STRAP_CPU4 2'h1
`define EMCP_STRAP_CPU6 2'h2
`define EMCP_STRAP_SETTLE 3'h4
`define EMCP_DIV_BY1 2'h0
`define EMCP_DIV_BY2 2'h1
`define EMCP_DIV_BY4 2'h2
`define EMCP_CPU4_HALF 2'h2
`define EMCP_CPU6_HALF 2'h3
`define EMCP_DIV2_RISES 2'h1
`define EMCP_DIV4_RISES 2'h2
`define EMCP_SETUP_CYC 4'h1
`define EMCP_STROBE_CYC 4'h2
`define EMCP_TAIL_CYC 4'h1
`define EMCP_SPACE_FIFO 2'h3
`endif

// ==== core/emcp_pkg.sv ====
// Types of the memory control pin block
package emcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_WAITRDY = 3'b011,
    ST_TAIL = 3'b100,
    ST_PARK = 3'b101,
    ST_HOLD = 3'b110
  } emcp_state_e;
  typedef enum logic [1:0] {
    MT_ASYNC = 2'b00,
    MT_SDRAM = 2'b01,
    MT_SYNC = 2'b10,
    MT_RSVD = 2'b11
  } emcp_mtype_e;
endpackage

// ==== core/emcp_sync3.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module emcp_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Pin side
  input wire logic [W-1:0] pin,
  // Filtered level
  output logic [W-1:0] val
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] val_q;
  wire agree = (s2_q == s3_q);
  wire [W-1:0] val_d = agree ? s3_q : val_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      val_q <= RST;
    end
    else if (clk_en)
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      val_q <= val_d;
    end
  end

  assign val = val_q;
endmodule

// ==== core/emcp_hcnt.sv ====
// Event counter that pulses every limit enabled events
`timescale 1ns/1ps
module emcp_hcnt #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Events and period
  input wire logic en,
  input wire logic [W-1:0] limit,
  // One-cycle pulse on the last event of a period
  output logic tick
);
  logic [W-1:0] cnt_q;
  wire last = (cnt_q >= limit - W'(1));
  wire [W-1:0] cnt_d = last ? '0 : cnt_q + W'(1);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (clk_en && en)
      cnt_q <= cnt_d;
  end

  assign tick = en && last;
endmodule

// ==== verif/emcp_ctrl_monitor.sv ====
// Checker for the memory control pin block
`timescale 1ns/1ps
module emcp_ctrl_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Access side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_done,
  // Memory pins
  input wire logic [3:0] chip_en_b,
  input wire logic rd_strobe_b,
  input wire logic oe_strobe_b,
  input wire logic wr_strobe_b,
  input wire logic fifo_space_out_en_b,
  input wire logic ctl_oe_b,
  // Arbitration
  input wire logic host_hold_req_in,
  input wire logic host_hold_ack_out,
  input wire logic bus_req_out
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_hold_quiet;
    host_hold_req_in && !req_valid;
  endsequence
  // Async waits may stretch an access, so only a bound is fixed
  a_take_done: assert property (s_take |=> (!req_done)[*4] ##[1:30] req_done)
    else $error("access done out of time");
  a_one_chip_en: assert property ($countones(~chip_en_b) <= 1)
    else $error("more than one chip enable low");
  a_strobe_has_ce: assert property ((!rd_strobe_b || !oe_strobe_b || !wr_strobe_b)
    |-> chip_en_b != 4'hF)
    else $error("strobe low without chip enable");
  a_fifo_space3: assert property (!fifo_space_out_en_b |-> !chip_en_b[3] && !oe_strobe_b)
    else $error("fifo enable outside space three");
  a_bus_req: assert property (req_valid |=> bus_req_out)
    else $error("bus request missing");
  a_ack_released: assert property (host_hold_ack_out |-> ctl_oe_b && !req_ready)
    else $error("acknowledge while pins driven");
  a_ack_after_park: assert property ($rose(host_hold_ack_out) |-> $past(ctl_oe_b))
    else $error("acknowledge before release");
  a_hold_answer: assert property (s_hold_quiet[*8] |-> ##[0:8] host_hold_ack_out)
    else $error("hold not acknowledged");
  a_ack_drops: assert property ((!host_hold_req_in)[*6] |-> !host_hold_ack_out)
    else $error("acknowledge without request");
endmodule
bind emcp_ctrl emcp_ctrl_monitor emcp_ctrl_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b),
  .req_valid(req_valid), .req_ready(req_ready), .req_done(req_done),
  .chip_en_b(chip_en_b), .rd_strobe_b(rd_strobe_b), .oe_strobe_b(oe_strobe_b),
  .wr_strobe_b(wr_strobe_b), .fifo_space_out_en_b(fifo_space_out_en_b),
  .ctl_oe_b(ctl_oe_b), .host_hold_req_in(host_hold_req_in),
  .host_hold_ack_out(host_hold_ack_out), .bus_req_out(bus_req_out));

// ==== verif/emcp_mem_model.sv ====
// Model of a slow asynchronous memory in space zero
`timescale 1ns/1ps
module emcp_mem_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Memory pins
  input wire logic [3:0] chip_en_b,
  input wire logic ctl_oe_b,
  input wire logic slow,
  output logic async_ready_in
);
  logic [3:0] wait_q;
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wait_q <= 4'h0;
    else if (chip_en_b[0] || ctl_oe_b)
      wait_q <= 4'h0;
    else if (wait_q != 4'hF)
      wait_q <= wait_q + 4'h1;
  end
  // Busy memory pulls ready low until six cycles into its access; pull-up otherwise
  assign async_ready_in = !slow || (wait_q > 4'h5);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for the memory control pin block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic req_valid, req_write, req_ready, req_done, ext_clk, full_clk, div_clk;
  logic [19:0] req_addr;
  logic [1:0] strap;
  logic rd_b, oe_b, wr_b, fifo_b, ctl_oe_b, ready, hreq, hack, breq, slow;
  logic oel, wrl, fl, brq;
  logic [3:0] ce_b, cel;
  int fails, total_checks, n, rfirst, p;
  always #25 sys_clk = ~sys_clk;
  emcp_ctrl emcp_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_ready(req_ready),
    .req_done(req_done), .clk_src_strap_pins(strap), .ext_if_clk_in(ext_clk),
    .mem_clk_out_full(full_clk), .mem_clk_out_div(div_clk), .chip_en_b(ce_b),
    .rd_strobe_b(rd_b), .oe_strobe_b(oe_b), .wr_strobe_b(wr_b),
    .fifo_space_out_en_b(fifo_b), .ctl_oe_b(ctl_oe_b), .async_ready_in(ready),
    .host_hold_req_in(hreq), .host_hold_ack_out(hack), .bus_req_out(breq));
  emcp_mem_model emcp_mem_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .chip_en_b(ce_b), .ctl_oe_b(ctl_oe_b), .slow(slow), .async_ready_in(ready));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Request stands until the edge that samples pready high; data are taken there
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Straps only change under reset, as board pulls would
  task automatic restart(input logic [1:0] s);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    strap <= s;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic per(input logic d, output int q);
    int k;
    logic prev, cur;
    k = -1;
    q = 0;
    prev = 1'b1;
    repeat (200)
    begin
      @(negedge sys_clk);
      cur = d ? div_clk : full_clk;
      if (k >= 0)
        k++;
      if (cur === 1'b1 && prev === 1'b0)
      begin
        if (k > 0)
        begin
          q = k;
          return;
        end
        k = 0;
      end
      prev = cur;
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] sp);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= {sp, 18'h0};
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 60);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    {n, rfirst, oel, wrl, fl, brq, cel} = '0;
    while (n < 60 && req_done !== 1'b1)
    begin
      @(negedge sys_clk);
      n++;
      if (rd_b === 1'b0 && rfirst == 0)
        rfirst = n;
      oel |= !oe_b;
      wrl |= !wr_b;
      fl |= !fifo_b;
      brq |= breq;
      cel |= ~ce_b;
    end
  endtask
  task automatic hold_test;
    logic seen;
    @(posedge sys_clk);
    hreq <= 1'b1;
    n = 0;
    while (hack !== 1'b1 && n < 30)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 30, 1'b1);
    chk(ctl_oe_b, 1'b1);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    seen = 1'b0;
    repeat (8)
    begin
      @(negedge sys_clk);
      seen |= req_ready;
    end
    chk(seen, 1'b0);
    @(posedge sys_clk);
    hreq <= 1'b0;
    req_valid <= 1'b0;
    repeat (10) @(negedge sys_clk);
    chk({hack, ctl_oe_b}, 2'h0);
    acc(1'b0, 2'h1);
    chk(n, 5);
  endtask
  ////////////////////////////////////////
  logic [1:0] st [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  int ep [4] = '{10, 6, 10, 4};
  task automatic clk_src_test;
    for (int i = 0; i < 4; i++)
    begin
      restart(st[i]);
      per(1'b0, p);
      chk(p, ep[i]);
    end
    apb(1'b0, 8'h08, 32'h0);
    chk(rd[1:0], 2'h1);
  endtask
  // The first divided period after a ratio change may be cut short, so the second is judged
  task automatic div_test;
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, 8'h00, j);
      per(1'b1, p);
      per(1'b1, p);
      chk(p, 4 << j);
    end
  endtask
  // Clocks stand still while the enable is low and resume at the same rate
  task automatic freeze_test;
    logic [1:0] held;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    @(negedge sys_clk);
    held = {full_clk, div_clk};
    repeat (10) @(negedge sys_clk);
    chk({full_clk, div_clk}, held);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    per(1'b0, p);
    chk(p, 4);
  endtask
  task automatic reg_test;
    restart(2'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
  endtask
  task automatic strobe_test;
    apb(1'b1, 8'h04, 32'h000000A4);
    for (int i = 0; i < 8; i++)
    begin
      acc(i[0], i[2:1]);
      chk(n, 5);
      chk(cel, 4'h1 << i[2:1]);
      chk(wrl, i[0]);
      chk(fl, i[2:1] == 2'h3 && !i[0]);
      chk(brq, 1'b1);
      if (!i[0])
        chk({oel, rfirst != 0}, 2'h3);
      if (!i[0] && i[2])
        chk(rfirst, 2);
    end
    apb(1'b1, 8'h00, 32'h4);
    acc(1'b0, 2'h3);
    chk(rfirst, 3);
  endtask
  task automatic ready_test;
    @(posedge sys_clk);
    slow <= 1'b1;
    acc(1'b0, 2'h0);
    @(posedge sys_clk);
    slow <= 1'b0;
    chk(n > 5 && n < 60, 1'b1);
  endtask
  initial
  begin
    {sys_clk, rst_b, psel, penable, pwrite, paddr, pwdata, req_valid} = '0;
    {req_write, req_addr, strap, ext_clk, hreq, slow, fails, total_checks} = '0;
    clk_en = 1'b1;
    clk_src_test();
    div_test();
    freeze_test();
    reg_test();
    strobe_test();
    ready_test();
    hold_test();
    finish_test();
  end
  initial
  begin
    #13;
    forever #250 ext_clk = ~ext_clk;
  end
  initial
  begin
    repeat (8000) @(posedge sys_clk);
    fails++;
    finish_test();
  end
endmodule
